// *** inc/aux_mode_pkg.sv ***
// Summary of operation
// (RULE_01) guard-early-done enable passes the guard-early-done flag to the interrupt.
// (RULE_02) stop clock keep holds the port clock running in stop mode.
// (RULE_03) wakeup enable raises the interrupt on the wakeup flag, only in stop mode.
// (RULE_04) wakeup select: 00 address match, 10 start bit, 11 rx full, 01 none.
// (RULE_05) card retry count bounds retransmissions and failed receptions; zero means none.
// (RULE_06) software writes retry count only when disabled, or zero when enabled.
// (RULE_07) driver enable output active high when polarity clear, low when set.
// (RULE_08) driver enable mode drives the driver enable onto the rts pin.
// (RULE_09) error without transfer-off: flag set, rx full stays low, no request.
// (RULE_10) error with transfer-off: flag and rx full set, request masked until cleared.
// (RULE_11) software drops rx request enable or rx full before clearing the error.
// (RULE_12) overrun flag on unread data unless overrun detection off, then overwrite.
// (RULE_13) three-sample majority or single sample; single disables noise, not for start.
// (RULE_14) cts change enable passes the cts change flag to the interrupt.
// (RULE_15) cts flow: send only while cts low, finish current character first.
// (RULE_16) rts flow: rts low only while the receive buffer has space.
// (RULE_17) remote stops after its current character once rts goes high.
// (RULE_18) tx and rx transfer-request enables allow the transfer requests.
// (RULE_19) card mode enable, with nack enable sends nack on parity error.
// (RULE_20) half duplex select, infrared enable and its low-power option.
// (RULE_21) error enable passes framing, overrun and noise flags to the interrupt.
// (RULE_22) mode settings are changed by software only while the port is disabled.
// (RULE_23) all enabled sources are ORed onto one level interrupt output.
package aux_mode_pkg;
   localparam logic [7:0] PORT_CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] AUX_MODE_OFF = 8'h08;
   localparam logic [7:0] RX_DATA_OFF = 8'h0C;
   localparam logic [31:0] AUX_MODE_RESET = 32'h0000_0000;
   localparam logic [31:0] AUX_MODE_WMASK = 32'h01FE_FFFF;
   localparam logic [1:0] WAKE_ADDR = 2'h0;
   localparam logic [1:0] WAKE_START = 2'h2;
   localparam logic [1:0] WAKE_RXFULL = 2'h3;
   localparam logic [7:0] SHORT_ADDR_MASK = 8'h0F;
   localparam logic [7:0] LONG_ADDR_MASK = 8'h7F;
   localparam int ST_PARITY = 0;
   localparam int ST_FRAMING = 1;
   localparam int ST_NOISE = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_RXF = 4;
   localparam int ST_CTS = 5;
   localparam int ST_WAKE = 6;
   localparam int ST_GTE = 7;
   localparam int ST_W = 8;

   typedef struct packed {
      logic [6:0] resv_hi;
      logic guard_early_done_irq_en;
      logic stop_clock_keep;
      logic wakeup_irq_en;
      logic [1:0] wakeup_event_select;
      logic [2:0] card_retry_count;
      logic resv16;
      logic driver_en_polarity;
      logic driver_en_mode;
      logic xfer_off_on_rx_error;
      logic overrun_detect_off;
      logic single_sample_sel;
      logic cts_change_irq_en;
      logic cts_flow_en;
      logic rts_flow_en;
      logic tx_xfer_req_en;
      logic rx_xfer_req_en;
      logic card_mode_en;
      logic card_nack_en;
      logic half_duplex_sel;
      logic infrared_low_power;
      logic infrared_mode_en;
      logic error_irq_en;
   } aux_cfg_t;

   typedef struct packed {
      logic char_valid;
      logic [8:0] data;
      logic parity_err;
      logic framing_err;
      logic start_seen;
   } rx_evt_t;

   typedef struct packed {
      logic char_busy;
      logic data_empty;
      logic nack_seen;
      logic guard_early_done;
      logic driving;
   } tx_evt_t;
endpackage : aux_mode_pkg

// *** verilog/serial_port_aux_mode_control.sv ***
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module serial_port_aux_mode_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire aux_mode_pkg::rx_evt_t rx_evt,
   input wire logic [2:0] rx_samples,
   input wire logic sample_strobe,
   input wire logic sample_is_start,
   input wire aux_mode_pkg::tx_evt_t tx_evt,
   input wire logic [7:0] node_addr,
   input wire logic long_address_sel,
   input wire logic stop_mode,
   input wire logic cts_n,
   output aux_mode_pkg::aux_cfg_t cfg,
   output logic port_enable,
   output logic rx_bit,
   output logic irq,
   output logic tx_req,
   output logic rx_req,
   output logic rts_pin,
   output logic tx_start_ok,
   output logic tx_retransmit,
   output logic card_nack_send,
   output logic clock_run
);
   localparam int W = aux_mode_pkg::ST_W;

   aux_mode_pkg::aux_cfg_t cfg_reg, cfg_next;
   logic en_reg, en_next;
   logic [W-1:0] st_reg, st_next;
   logic [8:0] rxd_reg, rxd_next;
   logic noise_seen_reg, noise_seen_next;
   logic [2:0] rx_try_reg, rx_try_next;
   logic [2:0] tx_try_reg, tx_try_next;
   logic cts_prev_reg, cts_prev_next;
   logic rx_bit_reg, rx_bit_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic irq_reg, irq_next;
   logic tx_req_reg, tx_req_next;
   logic rx_req_reg, rx_req_next;
   logic rts_reg, rts_next;
   logic tx_ok_reg, tx_ok_next;
   logic retx_reg, retx_next;
   logic nack_reg, nack_next;
   logic clk_reg, clk_next;

   logic wr_acc, rd_acc, setup;
   logic maj, noisy;
   logic err_now, parity_final, card_parity_bad;
   logic [W-1:0] set_v, clr_v;
   logic addr_hit, wake_ev;
   logic [7:0] amask;
   logic rxf_set, rxf_clr, rx_store, any_err;

   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pready_reg & pwrite;
   assign rd_acc = psel & penable & pready_reg & ~pwrite;

   // majority of three; start bit is always voted
   assign maj = (rx_samples[0] & rx_samples[1]) | (rx_samples[1] & rx_samples[2])
              | (rx_samples[0] & rx_samples[2]);
   assign noisy = ~(&rx_samples) & (|rx_samples)
                & (~cfg_reg.single_sample_sel | sample_is_start); // [RULE_13]

   assign amask = long_address_sel ? aux_mode_pkg::LONG_ADDR_MASK : aux_mode_pkg::SHORT_ADDR_MASK;
   assign addr_hit = ((rx_evt.data[7:0] ^ node_addr) & amask) == 8'h00;

   always_comb begin
      cfg_next = cfg_reg;
      en_next = en_reg;
      set_v = '0;
      clr_v = '0;
      rxd_next = rxd_reg;
      noise_seen_next = noise_seen_reg;
      rx_try_next = rx_try_reg;
      tx_try_next = tx_try_reg;
      rx_bit_next = rx_bit_reg;
      retx_next = 1'b0;
      nack_next = 1'b0;
      rxf_set = 1'b0;
      rx_store = 1'b0;
      card_parity_bad = 1'b0;
      parity_final = 1'b0;
      err_now = 1'b0;
      wake_ev = 1'b0;

      if (sample_strobe) begin
         rx_bit_next = (cfg_reg.single_sample_sel & ~sample_is_start) ? rx_samples[1] : maj; // [RULE_13]
         if (noisy) begin
            noise_seen_next = 1'b1;
         end
      end

      if (rx_evt.char_valid) begin
         noise_seen_next = 1'b0;
         card_parity_bad = cfg_reg.card_mode_en & rx_evt.parity_err;
         // card mode holds back parity errors until the trials run out
         if (card_parity_bad && rx_try_reg < cfg_reg.card_retry_count) begin
            rx_try_next = rx_try_reg + 3'h1; // [RULE_05]
         end else begin
            rx_try_next = 3'h0;
            parity_final = rx_evt.parity_err;
         end
         nack_next = card_parity_bad & cfg_reg.card_nack_en; // [RULE_19]
         err_now = parity_final | rx_evt.framing_err | noise_seen_reg;
         set_v[aux_mode_pkg::ST_PARITY] = parity_final;
         set_v[aux_mode_pkg::ST_FRAMING] = rx_evt.framing_err;
         set_v[aux_mode_pkg::ST_NOISE] = noise_seen_reg;
         if (card_parity_bad && !parity_final) begin
            rx_store = 1'b0;
         end else if (err_now) begin
            rx_store = cfg_reg.xfer_off_on_rx_error; // [RULE_09] [RULE_10]
         end else if (st_reg[aux_mode_pkg::ST_RXF] && !cfg_reg.overrun_detect_off) begin
            set_v[aux_mode_pkg::ST_OVERRUN] = 1'b1; // [RULE_12]
         end else begin
            rx_store = 1'b1; // [RULE_12]
         end
         if (rx_store) begin
            rxd_next = rx_evt.data;
            rxf_set = 1'b1;
         end
      end
      set_v[aux_mode_pkg::ST_RXF] = rxf_set;

      if (tx_evt.nack_seen && cfg_reg.card_mode_en) begin
         if (tx_try_reg < cfg_reg.card_retry_count) begin
            tx_try_next = tx_try_reg + 3'h1; // [RULE_05]
            retx_next = 1'b1;
         end else begin
            tx_try_next = 3'h0;
            set_v[aux_mode_pkg::ST_FRAMING] = 1'b1; // [RULE_05]
         end
      end else if (tx_evt.guard_early_done) begin
         tx_try_next = 3'h0;
      end
      set_v[aux_mode_pkg::ST_GTE] = tx_evt.guard_early_done;

      set_v[aux_mode_pkg::ST_CTS] = cts_n ^ cts_prev_reg;

      unique case (cfg_reg.wakeup_event_select) // [RULE_04]
         aux_mode_pkg::WAKE_ADDR: wake_ev = rx_evt.char_valid & addr_hit;
         aux_mode_pkg::WAKE_START: wake_ev = rx_evt.start_seen;
         aux_mode_pkg::WAKE_RXFULL: wake_ev = rxf_set;
         default: wake_ev = 1'b0;
      endcase
      set_v[aux_mode_pkg::ST_WAKE] = wake_ev;

      if (wr_acc) begin
         unique case (paddr)
            aux_mode_pkg::PORT_CTRL_OFF: en_next = pwdata[0];
            aux_mode_pkg::STATUS_OFF: clr_v = pwdata[W-1:0];
            aux_mode_pkg::AUX_MODE_OFF: begin
               cfg_next = aux_mode_pkg::aux_cfg_t'(pwdata & aux_mode_pkg::AUX_MODE_WMASK);
               // while enabled only zero may reach the retry count
               if (en_reg && pwdata[19:17] != 3'h0) begin
                  cfg_next.card_retry_count = cfg_reg.card_retry_count; // [RULE_06]
               end
            end
            default: ;
         endcase
      end
      if (rd_acc && paddr == aux_mode_pkg::RX_DATA_OFF) begin
         clr_v[aux_mode_pkg::ST_RXF] = 1'b1;
      end
      // set wins over clear
      st_next = (st_reg & ~clr_v) | set_v;
   end

   assign cts_prev_next = cts_n;

   always_comb begin
      prdata_next = prdata_reg;
      pready_next = setup;
      pslverr_next = 1'b0;
      if (setup) begin
         prdata_next = 32'h0000_0000;
         unique case (paddr)
            aux_mode_pkg::PORT_CTRL_OFF: prdata_next = {31'h0, en_reg};
            aux_mode_pkg::STATUS_OFF: prdata_next = {{(32-W){1'b0}}, st_reg};
            aux_mode_pkg::AUX_MODE_OFF: prdata_next = cfg_reg;
            aux_mode_pkg::RX_DATA_OFF: prdata_next = {23'h0, rxd_reg};
            default: pslverr_next = 1'b1;
         endcase
      end
   end

   assign any_err = st_reg[aux_mode_pkg::ST_PARITY] | st_reg[aux_mode_pkg::ST_FRAMING]
                  | st_reg[aux_mode_pkg::ST_NOISE];

   always_comb begin
      irq_next = (cfg_reg.guard_early_done_irq_en & st_reg[aux_mode_pkg::ST_GTE]) // [RULE_01]
               | (cfg_reg.wakeup_irq_en & st_reg[aux_mode_pkg::ST_WAKE] & stop_mode) // [RULE_03]
               | (cfg_reg.cts_change_irq_en & st_reg[aux_mode_pkg::ST_CTS]) // [RULE_14]
               | (cfg_reg.error_irq_en & (st_reg[aux_mode_pkg::ST_FRAMING] | st_reg[aux_mode_pkg::ST_OVERRUN]
                  | st_reg[aux_mode_pkg::ST_NOISE])); // [RULE_21] [RULE_23]
      tx_req_next = en_reg & cfg_reg.tx_xfer_req_en & tx_evt.data_empty; // [RULE_18]
      rx_req_next = en_reg & cfg_reg.rx_xfer_req_en & st_reg[aux_mode_pkg::ST_RXF]
                  & ~(cfg_reg.xfer_off_on_rx_error & any_err); // [RULE_18] [RULE_10]
      if (cfg_reg.driver_en_mode) begin
         rts_next = tx_evt.driving ^ cfg_reg.driver_en_polarity; // [RULE_07] [RULE_08]
      end else if (cfg_reg.rts_flow_en) begin
         rts_next = st_reg[aux_mode_pkg::ST_RXF]; // [RULE_16]
      end else begin
         rts_next = 1'b0;
      end
      // a character already on the wire is finished regardless of cts
      tx_ok_next = ~cfg_reg.cts_flow_en | tx_evt.char_busy | ~cts_n; // [RULE_15]
      clk_next = ~stop_mode | cfg_reg.stop_clock_keep; // [RULE_02]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= aux_mode_pkg::aux_cfg_t'(aux_mode_pkg::AUX_MODE_RESET);
         en_reg <= 1'b0;
         st_reg <= '0;
         rxd_reg <= 9'h000;
         noise_seen_reg <= 1'b0;
         rx_try_reg <= 3'h0;
         tx_try_reg <= 3'h0;
         cts_prev_reg <= 1'b1;
         rx_bit_reg <= 1'b1;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         irq_reg <= 1'b0;
         tx_req_reg <= 1'b0;
         rx_req_reg <= 1'b0;
         rts_reg <= 1'b0;
         tx_ok_reg <= 1'b0;
         retx_reg <= 1'b0;
         nack_reg <= 1'b0;
         clk_reg <= 1'b0;
      end else begin
         cfg_reg <= cfg_next;
         en_reg <= en_next;
         st_reg <= st_next;
         rxd_reg <= rxd_next;
         noise_seen_reg <= noise_seen_next;
         rx_try_reg <= rx_try_next;
         tx_try_reg <= tx_try_next;
         cts_prev_reg <= cts_prev_next;
         rx_bit_reg <= rx_bit_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         irq_reg <= irq_next;
         tx_req_reg <= tx_req_next;
         rx_req_reg <= rx_req_next;
         rts_reg <= rts_next;
         tx_ok_reg <= tx_ok_next;
         retx_reg <= retx_next;
         nack_reg <= nack_next;
         clk_reg <= clk_next;
      end
   end

   // half duplex and infrared bits are handed to the line logic as stored
   assign cfg = cfg_reg; // [RULE_20]
   assign port_enable = en_reg;
   assign rx_bit = rx_bit_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign tx_req = tx_req_reg;
   assign rx_req = rx_req_reg;
   assign rts_pin = rts_reg;
   assign tx_start_ok = tx_ok_reg;
   assign tx_retransmit = retx_reg;
   assign card_nack_send = nack_reg;
   assign clock_run = clk_reg;
endmodule : serial_port_aux_mode_control

// *** tb/aux_mode_monitor.sv ***
`timescale 1ns/1ps
module aux_mode_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire aux_mode_pkg::aux_cfg_t cfg,
   input wire logic stop_mode,
   input wire logic cts_n,
   input wire aux_mode_pkg::tx_evt_t tx_evt,
   input wire logic irq,
   input wire logic tx_req,
   input wire logic rx_req,
   input wire logic rts_pin,
   input wire logic tx_start_ok,
   input wire logic tx_retransmit,
   input wire logic card_nack_send,
   input wire logic clock_run
);
   logic others;
   assign others = cfg.guard_early_done_irq_en | cfg.cts_change_irq_en | cfg.error_irq_en;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_pready_once: assert property (psel && !penable |=> pready ##1 !pready) else $error("pready not one cycle");
   a_clock_stop: assert property (1 |=> clock_run == $past(!stop_mode || cfg.stop_clock_keep))
      else $error("clock_run wrong");
   a_irq_quiet: assert property (!(others || cfg.wakeup_irq_en) |=> !irq) else $error("irq with no enable");
   a_wake_awake: assert property (!others && !stop_mode |=> !irq) else $error("wake irq outside stop");
   a_cts_hold: assert property (cfg.cts_flow_en && cts_n && !tx_evt.char_busy |=> !tx_start_ok)
      else $error("tx start, cts high");
   a_rts_off: assert property (!cfg.rts_flow_en && !cfg.driver_en_mode |=> !rts_pin) else $error("rts driven");
   a_retry_zero: assert property (tx_retransmit |-> $past(cfg.card_retry_count) != 3'h0)
      else $error("retransmit with zero count");
   a_nack_mode: assert property (card_nack_send |-> $past(cfg.card_mode_en && cfg.card_nack_en))
      else $error("nack not enabled");
   a_req_gate: assert property ((rx_req |-> $past(cfg.rx_xfer_req_en)) and (tx_req |-> $past(cfg.tx_xfer_req_en)))
      else $error("request not enabled");
   cover property (tx_retransmit);
   cover property (card_nack_send);
   cover property (stop_mode && irq);
   cover property (rx_req);
endmodule : aux_mode_monitor
bind serial_port_aux_mode_control aux_mode_monitor aux_mode_monitor_i (.pclk, .presetn, .psel, .penable, .pready,
   .cfg, .stop_mode, .cts_n, .tx_evt, .irq, .tx_req, .rx_req, .rts_pin, .tx_start_ok, .tx_retransmit, .card_nack_send,
   .clock_run);

// *** tb/remote_serial_peer.sv ***
`timescale 1ns/1ps
module remote_serial_peer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rts_pin,
   input wire logic honor_rts,
   input wire logic send,
   input wire logic [10:0] chr,
   output aux_mode_pkg::rx_evt_t rx_evt
);
   logic pend_reg;
   logic [10:0] hold_reg;
   // a queued character waits while honor_rts and rts are high; a new send replaces it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 1'b0;
         hold_reg <= '0;
         rx_evt <= '0;
      end else begin
         rx_evt.start_seen <= send;
         rx_evt.char_valid <= 1'b0;
         // data is garbage between characters
         rx_evt.data <= ~rx_evt.data;
         if (send) begin
            pend_reg <= 1'b1;
            hold_reg <= chr;
         end else if (pend_reg && !(honor_rts && rts_pin)) begin
            pend_reg <= 1'b0;
            rx_evt.char_valid <= 1'b1;
            {rx_evt.parity_err, rx_evt.framing_err, rx_evt.data} <= hold_reg;
         end
      end
   end
endmodule : remote_serial_peer

// *** tb/serial_port_aux_mode_control_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s exp %0h got %0h", n, e, g); end end
module serial_port_aux_mode_control_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_strobe, sample_is_start, long_address_sel;
   logic stop_mode, cts_n, port_enable, rx_bit, irq, tx_req, rx_req, rts_pin, tx_start_ok, tx_retransmit;
   logic card_nack_send, clock_run, send, honor_rts, er, nk_exp;
   logic [7:0] paddr, node_addr;
   logic [31:0] pwdata, prdata, rd, w;
   logic [2:0] rx_samples;
   logic [10:0] chr;
   logic [8:0] a, b;
   aux_mode_pkg::rx_evt_t rx_evt;
   aux_mode_pkg::tx_evt_t tx_evt;
   aux_mode_pkg::aux_cfg_t cfg;
   int err_count = 0;
   int samples_checked = 0;
   serial_port_aux_mode_control serial_port_aux_mode_control_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_evt, .rx_samples, .sample_strobe, .sample_is_start, .tx_evt,
      .node_addr, .long_address_sel, .stop_mode, .cts_n, .cfg, .port_enable, .rx_bit, .irq, .tx_req, .rx_req,
      .rts_pin, .tx_start_ok, .tx_retransmit, .card_nack_send, .clock_run);
   remote_serial_peer remote_serial_peer_i (.pclk, .presetn, .rts_pin, .honor_rts, .send, .chr, .rx_evt);
   function automatic logic [31:0] exp_cfg(input logic [31:0] old, input logic [31:0] d, input logic en);
      exp_cfg = d & aux_mode_pkg::AUX_MODE_WMASK;
      if (en && d[19:17] != 3'h0) exp_cfg[19:17] = old[19:17];
   endfunction : exp_cfg
   function automatic logic maj(input logic [2:0] s);
      maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj
   task automatic summarize;
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t >= 20) err_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // return after the access edge so callers see the registered result
      #1;
   endtask : apb
   task automatic chk_rd(input string n, input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      `CHK(n, e, rd)
   endtask : chk_rd
   task automatic hold(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : hold
   task automatic rx_char(input logic [10:0] c);
      @(posedge pclk);
      chr <= c;
      send <= 1'b1;
      @(posedge pclk);
      send <= 1'b0;
      hold(2);
      `CHK("nack", nk_exp, card_nack_send)
      hold(3);
   endtask : rx_char
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      // whole run needs under two thousand cycles
      repeat (5000) @(posedge pclk);
      err_count++;
      summarize();
   end
   initial begin
      {psel, penable, pwrite, sample_strobe, sample_is_start, long_address_sel, stop_mode, cts_n} = '0;
      {send, honor_rts, nk_exp, paddr, pwdata, rx_samples, chr} = '0;
      node_addr = 8'h0F;
      tx_evt = 5'h08;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      void'($urandom(32'hC8EC));
      chk_rd("cfg_reset", 8'h08, 32'h0);
      chk_rd("unmapped", 8'h10, 32'h0);
      `CHK("slverr", 1'b1, er)
      for (int i = 0; i < 4; i++) begin
         w = $urandom;
         apb(1'b1, 8'h08, w);
         chk_rd("cfg_rw", 8'h08, exp_cfg(32'h0, w, 1'b0));
         `CHK("cfg_out", exp_cfg(32'h0, w, 1'b0), cfg)
      end
      apb(1'b1, 8'h08, 32'h0004_0030);
      apb(1'b1, 8'h00, 32'h1);
      `CHK("port_en", 1'b1, port_enable)
      apb(1'b1, 8'h08, 32'h000E_0030);
      chk_rd("retry_kept", 8'h08, exp_cfg(32'h0004_0030, 32'h000E_0030, 1'b1));
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'hFF);
      for (int k = 0; k < 3; k++) begin
         @(posedge pclk);
         tx_evt.nack_seen <= 1'b1;
         @(posedge pclk);
         tx_evt.nack_seen <= 1'b0;
         #1;
         `CHK("retransmit", k < 2, tx_retransmit)
      end
      nk_exp = 1'b1;
      rx_char({2'b10, 9'h001});
      nk_exp = 1'b0;
      chk_rd("card_status", 8'h04, 32'h2);
      apb(1'b1, 8'h08, 32'hC1);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h04, 32'hFF);
      `CHK("tx_req", 1'b1, tx_req)
      a = 9'h1F0 & 9'($urandom) | 9'h001;
      rx_char({2'b01, a});
      `CHK("err_no_req", 1'b0, rx_req)
      `CHK("err_irq", 1'b1, irq)
      chk_rd("err_status", 8'h04, 32'h2);
      apb(1'b1, 8'h04, 32'hFF);
      rx_char({2'b00, a});
      `CHK("good_req", 1'b1, rx_req)
      chk_rd("good_data", 8'h0C, {23'h0, a});
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'h2040);
      apb(1'b1, 8'h00, 32'h1);
      rx_char({2'b10, a});
      `CHK("mask_req", 1'b0, rx_req)
      `CHK("tx_req_off", 1'b0, tx_req)
      chk_rd("mask_status", 8'h04, 32'h11);
      chk_rd("mask_data", 8'h0C, {23'h0, a});
      apb(1'b1, 8'h04, 32'hFF);
      apb(1'b1, 8'h00, 32'h0);
      b = a ^ 9'h100;
      for (int od = 0; od < 2; od++) begin
         apb(1'b1, 8'h08, od ? 32'h1000 : 32'h0);
         rx_char({2'b00, a});
         rx_char({2'b00, b});
         chk_rd("overrun", 8'h04, od ? 32'h10 : 32'h18);
         chk_rd("ovr_data", 8'h0C, {23'h0, od ? b : a});
         apb(1'b1, 8'h04, 32'hFF);
      end
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 8'h08, 32'h0040_0000 | (32'(s) << 20) | (32'(s % 2) << 23));
         apb(1'b1, 8'h04, 32'hFF);
         rx_char(11'h00F);
         `CHK("wake_awake", 1'b0, irq)
         stop_mode <= 1'b1;
         hold(3);
         `CHK("wake_irq", s != 1, irq)
         `CHK("clock_run", s % 2, clock_run)
         stop_mode <= 1'b0;
         chk_rd("wake_data", 8'h0C, 32'h00F);
      end
      apb(1'b1, 8'h08, 32'h0100);
      apb(1'b1, 8'h04, 32'hFF);
      honor_rts <= 1'b1;
      rx_char({2'b00, a});
      `CHK("rts_full", 1'b1, rts_pin)
      rx_char({2'b00, b});
      chk_rd("rts_no_ovr", 8'h04, 32'h10);
      chk_rd("rts_first", 8'h0C, {23'h0, a});
      hold(6);
      chk_rd("rts_second", 8'h0C, {23'h0, b});
      apb(1'b1, 8'h08, 32'h0100_0600);
      apb(1'b1, 8'h04, 32'hFF);
      cts_n <= 1'b1;
      hold(3);
      `CHK("cts_block", 1'b0, tx_start_ok)
      `CHK("cts_irq", 1'b1, irq)
      tx_evt.char_busy <= 1'b1;
      hold(2);
      `CHK("cts_finish", 1'b1, tx_start_ok)
      tx_evt.char_busy <= 1'b0;
      apb(1'b1, 8'h04, 32'hFF);
      tx_evt.guard_early_done <= 1'b1;
      hold(1);
      tx_evt.guard_early_done <= 1'b0;
      hold(2);
      `CHK("guard_irq", 1'b1, irq)
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, 8'h08, p ? 32'hC000 : 32'h4000);
         tx_evt.driving <= 1'b1;
         hold(2);
         `CHK("drv_pin", p == 0, rts_pin)
         tx_evt.driving <= 1'b0;
      end
      apb(1'b1, 8'h08, 32'h0);
      for (int i = 0; i < 8; i++) begin
         if (i == 4) apb(1'b1, 8'h08, 32'h0800);
         @(posedge pclk);
         rx_samples <= 3'($urandom);
         sample_strobe <= 1'b1;
         @(posedge pclk);
         sample_strobe <= 1'b0;
         hold(1);
         `CHK("sample", (i < 4) ? maj(rx_samples) : rx_samples[1], rx_bit)
      end
      summarize();
   end
endmodule : serial_port_aux_mode_control_tb
